// *** hdl/ts_regs_alert.v ***
// Register file, conversion sequencer and thermal alert of the sensor.
// Assumes bus framing logic on clk_sys hands over whole bytes, and the
// converter answers each conv_start_q pulse with one conv_done pulse.
`timescale 1ns/1ps
`include "ts_defs.vh"

module ts_regs_alert #(
  parameter [31:0] PERIOD0_CYC = `TS_CLK_MHZ * 1000 * `TS_PERIOD0_MS,
  parameter [31:0] PERIOD1_CYC = `TS_CLK_MHZ * 1000 * `TS_PERIOD1_MS,
  parameter [31:0] PERIOD2_CYC = `TS_CLK_MHZ * 1000 * `TS_PERIOD2_MS,
  parameter [31:0] PERIOD3_CYC = `TS_CLK_MHZ * 1000 * `TS_PERIOD3_MS
) (
  input wire clk_sys, // System clock
  input wire reset_n, // Async reset, active low
  input wire gc_reset, // General call reset pulse
  input wire frame_edge, // Start or stop seen, restarts byte order
  input wire wr_valid, // Received byte strobe
  input wire wr_is_pointer, // Strobed byte is the pointer byte
  input wire [7:0] wr_data, // Received byte
  input wire rd_take, // Byte on rd_data_q was shifted out
  input wire alert_resp, // Device answered alert response address
  input wire conv_done, // Converter finished
  input wire [12:0] conv_data, // Converter value, 13-bit two's complement
  output reg [7:0] rd_data_q, // Byte to send next
  output reg conv_start_q, // Start one conversion
  output reg alert_oe_q, // Open-drain alert pulls low when high
  output reg alert_level_q // Logical alert pin level
);

  reg [1:0] ptr_q; // Register selected
  reg byte_q; // 0 high byte, 1 low byte
  reg [12:0] temp_q;
  reg [15:0] upper_q;
  reg [15:0] lower_q;
  reg os_q, pol_q, tm_q, sd_q, em_q, os_pend_q;
  reg [1:0] fq_q, cr_q;
  reg [1:0] st_q;
  reg [31:0] tmr_q;
  reg comp_q, int_q, arm_hi_q;
  reg [2:0] ccnt_q, icnt_q;

  // Value to register image
  function [15:0] fmt;
    input [12:0] v;
    input em;
    begin
      fmt = em ? {v, 3'h1} : {v[11:0], 4'h0};
    end
  endfunction

  // Register image to signed 13-bit value
  function [12:0] val;
    input [15:0] r;
    input em;
    begin
      val = em ? r[15:3] : {r[15], r[15:4]};
    end
  endfunction

  wire [15:0] cfg_w = {os_q, `TS_RES_READBACK, fq_q, pol_q, tm_q, sd_q,
                       cr_q, ~comp_q ^ pol_q, em_q, 4'h0};
  reg [15:0] sel_w;
  always @* begin
    case (ptr_q)
      `TS_SEL_RESULT: sel_w = fmt(temp_q, em_q);
      `TS_SEL_CONFIG: sel_w = cfg_w;
      `TS_SEL_LOWER: sel_w = lower_q;
      default: sel_w = upper_q;
    endcase
  end

  reg [2:0] run_w;
  always @* begin
    case (fq_q)
      2'h0: run_w = `TS_RUN_0;
      2'h1: run_w = `TS_RUN_1;
      2'h2: run_w = `TS_RUN_2;
      default: run_w = `TS_RUN_3;
    endcase
  end

  reg [31:0] period_w;
  always @* begin
    case (cr_q)
      2'h0: period_w = PERIOD0_CYC;
      2'h1: period_w = PERIOD1_CYC;
      2'h2: period_w = PERIOD2_CYC;
      default: period_w = PERIOD3_CYC;
    endcase
  end

  wire signed [12:0] t_s = conv_data;
  wire signed [12:0] hi_s = val(upper_q, em_q);
  wire signed [12:0] lo_s = val(lower_q, em_q);
  wire at_hi = t_s >= hi_s;
  wire below_lo = t_s < lo_s;
  wire done_w = (st_q == `TS_ST_CONV) && conv_done;
  wire cfg_hi_wr = wr_valid && !wr_is_pointer && ptr_q == `TS_SEL_CONFIG && !byte_q;
  wire sd_rise = cfg_hi_wr && wr_data[`TS_B1_SHUTDOWN] && !sd_q;
  wire c_cond = comp_q ? below_lo : at_hi;
  wire i_cond = arm_hi_q ? at_hi : below_lo;
  // Interrupt state moves only in interrupt mode, so comparator history cannot fire it
  wire i_set = tm_q && done_w && !int_q && i_cond && (icnt_q + 3'h1 >= run_w);
  // Register read, alert response or entering shutdown
  wire i_clr = tm_q && ((rd_take && byte_q == 1'b0) || alert_resp || sd_rise);
  wire alert_act = tm_q ? int_q : comp_q;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ptr_q <= `TS_SEL_RESULT;
      byte_q <= 1'b0;
      temp_q <= 13'h0000;
      upper_q <= `TS_RST_UPPER;
      lower_q <= `TS_RST_LOWER;
      os_q <= 1'b0;
      os_pend_q <= 1'b0;
      fq_q <= `TS_RST_FAULT;
      pol_q <= 1'b0;
      tm_q <= 1'b0;
      sd_q <= 1'b0;
      cr_q <= `TS_RST_RATE;
      em_q <= 1'b0;
      st_q <= `TS_ST_START;
      tmr_q <= 32'h0000_0000;
      comp_q <= 1'b0;
      int_q <= 1'b0;
      arm_hi_q <= 1'b1;
      ccnt_q <= 3'h0;
      icnt_q <= 3'h0;
      conv_start_q <= 1'b0;
      rd_data_q <= 8'h00;
      alert_oe_q <= 1'b0;
      alert_level_q <= 1'b1;
    end else if (gc_reset) begin
      ptr_q <= `TS_SEL_RESULT;
      byte_q <= 1'b0;
      temp_q <= 13'h0000;
      upper_q <= `TS_RST_UPPER;
      lower_q <= `TS_RST_LOWER;
      os_q <= 1'b0;
      os_pend_q <= 1'b0;
      fq_q <= `TS_RST_FAULT;
      pol_q <= 1'b0;
      tm_q <= 1'b0;
      sd_q <= 1'b0;
      cr_q <= `TS_RST_RATE;
      em_q <= 1'b0;
      st_q <= `TS_ST_START;
      tmr_q <= 32'h0000_0000;
      comp_q <= 1'b0;
      int_q <= 1'b0;
      arm_hi_q <= 1'b1;
      ccnt_q <= 3'h0;
      icnt_q <= 3'h0;
      conv_start_q <= 1'b0;
      rd_data_q <= 8'h00;
      alert_oe_q <= 1'b0;
      alert_level_q <= 1'b1;
    end else begin
      conv_start_q <= 1'b0;
      // Byte order and pointer
      if (frame_edge) begin
        byte_q <= 1'b0;
      end else if (wr_valid && wr_is_pointer) begin
        ptr_q <= wr_data[1:0];
        byte_q <= 1'b0;
      end else if (wr_valid || rd_take) begin
        byte_q <= ~byte_q;
      end
      // Byte-wise register writes
      if (wr_valid && !wr_is_pointer && !frame_edge) begin
        case (ptr_q)
          `TS_SEL_CONFIG: begin
            if (!byte_q) begin
              fq_q <= wr_data[`TS_B1_FAULT_HI:`TS_B1_FAULT_LO];
              pol_q <= wr_data[`TS_B1_ACT_LEVEL];
              tm_q <= wr_data[`TS_B1_THERMO];
              sd_q <= wr_data[`TS_B1_SHUTDOWN];
              if (wr_data[`TS_B1_ONE_SHOT] && sd_q && st_q == `TS_ST_SHUT) begin
                os_pend_q <= 1'b1;
                os_q <= 1'b0;
              end
            end else begin
              cr_q <= wr_data[`TS_B2_RATE_HI:`TS_B2_RATE_LO];
              em_q <= wr_data[`TS_B2_EXT_RANGE];
            end
          end
          `TS_SEL_LOWER: begin
            if (!byte_q) lower_q[15:8] <= wr_data;
            else lower_q[7:0] <= wr_data;
          end
          `TS_SEL_UPPER: begin
            if (!byte_q) upper_q[15:8] <= wr_data;
            else upper_q[7:0] <= wr_data;
          end
          default: begin
          end
        endcase
      end
      rd_data_q <= (byte_q ^ rd_take) ? sel_w[7:0] : sel_w[15:8];

      // Conversion sequencer
      tmr_q <= tmr_q + 32'h0000_0001;
      case (st_q)
        `TS_ST_START: begin
          conv_start_q <= 1'b1;
          tmr_q <= 32'h0000_0000;
          st_q <= `TS_ST_CONV;
        end
        `TS_ST_CONV: begin
          if (conv_done) begin
            temp_q <= conv_data;
            if (sd_q) begin
              st_q <= `TS_ST_SHUT;
              if (os_pend_q) os_q <= 1'b1;
              os_pend_q <= 1'b0;
            end else begin
              st_q <= `TS_ST_WAIT;
            end
          end
        end
        `TS_ST_WAIT: begin
          if (sd_q) st_q <= `TS_ST_SHUT;
          else if (tmr_q + 32'h0000_0001 >= period_w) st_q <= `TS_ST_START;
        end
        `TS_ST_SHUT: begin
          if (!sd_q || os_pend_q) st_q <= `TS_ST_START;
        end
        default: st_q <= `TS_ST_START;
      endcase

      // Comparator hysteresis, also feeds the limit flag
      if (done_w) begin
        if (c_cond) begin
          if (ccnt_q + 3'h1 >= run_w) begin
            comp_q <= ~comp_q;
            ccnt_q <= 3'h0;
          end else begin
            ccnt_q <= ccnt_q + 3'h1;
          end
        end else begin
          ccnt_q <= 3'h0;
        end
      end

      // Interrupt alert; a set in the clear cycle wins
      if (i_set) begin
        int_q <= 1'b1;
        icnt_q <= 3'h0;
      end else if (i_clr && int_q) begin
        int_q <= 1'b0;
        arm_hi_q <= ~arm_hi_q;
      end else if (tm_q && done_w && !int_q) begin
        icnt_q <= i_cond ? icnt_q + 3'h1 : 3'h0;
      end

      alert_level_q <= alert_act ? pol_q : ~pol_q;
      alert_oe_q <= ~(alert_act ? pol_q : ~pol_q);
    end
  end

endmodule

// *** hdl/ts_defs.vh ***
// Constants for the temperature sensor register file and alert logic.
// Assumes the includer runs on a single 100 MHz system clock.
`ifndef TS_DEFS_VH
`define TS_DEFS_VH

// Register select codes
`define TS_SEL_RESULT 2'h0
`define TS_SEL_CONFIG 2'h1
`define TS_SEL_LOWER 2'h2
`define TS_SEL_UPPER 2'h3

// Configuration first byte fields
`define TS_B1_ONE_SHOT 7
`define TS_B1_FAULT_HI 4
`define TS_B1_FAULT_LO 3
`define TS_B1_ACT_LEVEL 2
`define TS_B1_THERMO 1
`define TS_B1_SHUTDOWN 0
`define TS_RES_READBACK 2'h3

// Configuration second byte fields
`define TS_B2_RATE_HI 7
`define TS_B2_RATE_LO 6
`define TS_B2_LIMIT_FLAG 5
`define TS_B2_EXT_RANGE 4

// Reset values
`define TS_RST_FAULT 2'h0
`define TS_RST_RATE 2'h2
`define TS_RST_UPPER 16'h5000
`define TS_RST_LOWER 16'h4b00

// Fault run lengths
`define TS_RUN_0 3'h1
`define TS_RUN_1 3'h2
`define TS_RUN_2 3'h4
`define TS_RUN_3 3'h6

// Timing
`define TS_CLK_MHZ 100
`define TS_PERIOD0_MS 4000
`define TS_PERIOD1_MS 1000
`define TS_PERIOD2_MS 250
`define TS_PERIOD3_MS 125

// Sequencer states
`define TS_ST_START 2'h0
`define TS_ST_CONV 2'h1
`define TS_ST_WAIT 2'h2
`define TS_ST_SHUT 2'h3

`endif

// *** sim/ts_conv_model.sv ***
// Converter stand-in: each start gets one done pulse.
// Assumes start is a one-cycle pulse on clk_sys.
`timescale 1ns/1ps
module ts_conv_model #(parameter int DELAY = 4) (
  input wire logic clk_sys, // Clock
  input wire logic reset_n, // Reset, active low
  input wire logic start, // Request
  input wire logic [12:0] value, // Reported value
  output logic done, // Result strobe
  output logic [12:0] data // Result
);
  int cnt;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      cnt <= 0;
    else if (start)
      cnt <= DELAY;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  assign done = (cnt == 1);
  // Scrambled outside the strobe
  assign data = done ? value : ~value;
endmodule

// *** sim/ts_regs_alert_props.sv ***
// Port checks for ts_regs_alert.
// Assumes one clk_sys domain; bound at the foot.
`timescale 1ns/1ps
module ts_regs_alert_props (
  input wire clk_sys, // Clock
  input wire reset_n, // Reset
  input wire gc_reset, // General reset
  input wire frame_edge, // Frame edge
  input wire wr_valid, // Byte strobe
  input wire wr_is_pointer, // Pointer byte
  input wire [7:0] wr_data, // Byte
  input wire rd_take, // Byte sent
  input wire alert_resp, // Alert answer
  input wire conv_done, // Converted
  input wire [12:0] conv_data, // Value
  input wire [7:0] rd_data_q, // Read byte
  input wire conv_start_q, // Start
  input wire alert_oe_q, // Pull-down
  input wire alert_level_q // Level
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  a_pin_pair: assert property (alert_level_q == !alert_oe_q)
    else $error("alert pins disagree");
  a_start_once: assert property (conv_start_q |=> !conv_start_q)
    else $error("start too long");
  a_start_gap: assert property (disable iff (!reset_n || gc_reset) conv_start_q |=> !conv_start_q [*8])
    else $error("starts too close");
  a_first_start: assert property ($rose(reset_n) |-> ##[1:2] conv_start_q)
    else $error("no start after reset");
  a_gc_clear: assert property (gc_reset |=> !alert_oe_q && alert_level_q)
    else $error("alert kept over reset");
  a_gc_start: assert property (gc_reset |=> ##[0:2] conv_start_q)
    else $error("no start after reset");
  a_res_bits: assert property (wr_valid && wr_is_pointer && wr_data[1:0] == 2'h1 ##1 !wr_valid && !rd_take
    && !frame_edge |=> rd_data_q[6:5] == 2'h3)
    else $error("resolution bits wrong");
  a_alert_cause: assert property ($changed(alert_oe_q) |-> $past(conv_done | rd_take | alert_resp | wr_valid
    | gc_reset) || $past(conv_done | rd_take | alert_resp | wr_valid | gc_reset, 2))
    else $error("alert moved without cause");
endmodule
bind ts_regs_alert ts_regs_alert_props i_props (.*);

// *** sim/ts_regs_alert_tb.sv ***
// Bench for ts_regs_alert.
// Assumes ts_conv_model acts as converter.
`timescale 1ns/1ps
module ts_regs_alert_tb;
  logic clk_sys = 0, reset_n = 0, gc_reset = 0, frame_edge = 0, wr_valid = 0, wr_is_pointer = 0;
  logic rd_take = 0, alert_resp = 0, conv_done, conv_start_q, alert_oe_q, alert_level_q;
  logic [7:0] wr_data = 0, rd_data_q;
  logic [12:0] conv_data, temp = 13'h0400;
  logic [15:0] v;
  int fails = 0, check_count = 0, cycles = 0, n;
  ts_regs_alert #(.PERIOD0_CYC(40), .PERIOD1_CYC(30), .PERIOD2_CYC(20), .PERIOD3_CYC(10)) i_dut (.*);
  ts_conv_model i_conv (.clk_sys(clk_sys), .reset_n(reset_n), .start(conv_start_q), .value(temp),
    .done(conv_done), .data(conv_data));
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 20000) begin
      fails++;
      summarize();
    end
  end
  task summarize();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wb(input logic p, input logic [7:0] b);
    @(negedge clk_sys);
    wr_valid = 1;
    wr_is_pointer = p;
    wr_data = b;
    @(negedge clk_sys);
    wr_valid = 0;
    wr_data = ~b;
  endtask
  task frame();
    @(negedge clk_sys);
    frame_edge = 1;
    @(negedge clk_sys);
    frame_edge = 0;
  endtask
  task wreg(input logic [7:0] p, input logic [15:0] d);
    wb(1, p);
    wb(0, d[15:8]);
    wb(0, d[7:0]);
    frame();
  endtask
  task rd(input logic [7:0] p);
    wb(1, p);
    @(negedge clk_sys);
    v[15:8] = rd_data_q;
    rd_take = 1;
    @(negedge clk_sys);
    rd_take = 0;
    @(negedge clk_sys);
    v[7:0] = rd_data_q;
    frame();
  endtask
  task conv(input logic [12:0] t);
    temp = t;
    n = 0;
    @(negedge clk_sys);
    while (conv_done !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    chk(16'(conv_done), 16'h1);
    repeat (2) @(negedge clk_sys);
  endtask
  task t_regs();
    conv(13'h0400);
    rd(8'h01);
    chk(v, 16'h60a0);
    rd(8'h02);
    chk(v, 16'h4b00);
    rd(8'h03);
    chk(v, 16'h5000);
    rd(8'hfc);
    chk(v, 16'h4000);
    wb(1, 8'h03);
    wb(0, 8'h55);
    frame();
    rd(8'h03);
    chk(v, 16'h5500);
    wreg(8'h00, 16'hffff);
    rd(8'h00);
    chk(v, 16'h4000);
    wreg(8'h01, 16'h0000);
    rd(8'h01);
    chk(v, 16'h6020);
    wreg(8'h01, 16'h0010);
    conv(13'h0400);
    rd(8'h00);
    chk(v, 16'h2001);
    wreg(8'h03, 16'h5000);
    $display("t_regs done");
  endtask
  task t_alert();
    wreg(8'h01, 16'h10a0);
    for (int i = 1; i <= 4; i++) begin
      conv(13'h0500);
      chk(16'(alert_oe_q), 16'(i == 4));
    end
    rd(8'h01);
    chk(v, 16'h7080);
    for (int i = 1; i <= 4; i++) begin
      conv(13'h0400);
      chk(16'(alert_oe_q), 16'(i < 4));
    end
    wreg(8'h01, 16'h02a0);
    conv(13'h0500);
    chk(16'(alert_oe_q), 16'h1);
    rd(8'h00);
    chk(16'(alert_oe_q), 16'h0);
    conv(13'h0500);
    chk(16'(alert_oe_q), 16'h0);
    conv(13'h0400);
    chk(16'(alert_oe_q), 16'h1);
    @(negedge clk_sys);
    alert_resp = 1;
    @(negedge clk_sys);
    alert_resp = 0;
    @(negedge clk_sys);
    chk(16'(alert_oe_q), 16'h0);
    conv(13'h0500);
    wreg(8'h01, 16'h03a0);
    chk(16'(alert_oe_q), 16'h0);
    $display("t_alert done");
  endtask
  task t_oneshot();
    repeat (30) @(negedge clk_sys);
    wb(1, 8'h01);
    wb(0, 8'h83);
    conv(13'h0500);
    rd(8'h01);
    chk(v, 16'he380);
    n = 0;
    repeat (60) begin
      @(negedge clk_sys);
      n += conv_start_q;
    end
    chk(16'(n), 16'h0);
    wreg(8'h01, 16'h00a0);
    conv(13'h0500);
    chk(16'(alert_oe_q), 16'h1);
    temp = 13'h0400;
    @(negedge clk_sys);
    gc_reset = 1;
    @(negedge clk_sys);
    gc_reset = 0;
    chk(16'(alert_oe_q), 16'h0);
    conv(13'h0400);
    rd(8'h01);
    chk(v, 16'h60a0);
    wreg(8'h01, 16'h04a0);
    chk(16'(alert_oe_q), 16'h1);
    chk(16'(alert_level_q), 16'h0);
    $display("t_oneshot done");
  endtask
  initial begin
    repeat (20) @(negedge clk_sys);
    reset_n = 1;
    t_regs();
    t_alert();
    t_oneshot();
    summarize();
  end
endmodule
